// ### design/ltw_pkg.sv
// constants, register map and state types for the line trigger wait block
package ltw_pkg;
   localparam int unsigned AW       = 4;
   localparam int unsigned DW       = 16;
   localparam int unsigned NUM_OUT  = 2;
   localparam int unsigned STAT_W   = 4;
   localparam int unsigned JIT_W    = 4;

   // register indices on the plain register port
   localparam logic [AW-1:0] REG_CTRL        = 4'h0;
   localparam logic [AW-1:0] REG_EXPOSURE    = 4'h1;
   localparam logic [AW-1:0] REG_OVERLAP     = 4'h2;
   localparam logic [AW-1:0] REG_READOUT     = 4'h3;
   localparam logic [AW-1:0] REG_HEIGHT      = 4'h4;
   localparam logic [AW-1:0] REG_TX_DELAY    = 4'h5;
   localparam logic [AW-1:0] REG_LINE_SELECT = 4'h6;
   localparam logic [AW-1:0] REG_LINE_SOURCE = 4'h7;
   localparam logic [AW-1:0] REG_STATUS      = 4'h8;
   localparam logic [AW-1:0] REG_MASK        = 4'h9;
   localparam logic [AW-1:0] REG_STATE       = 4'hA;

   // control register bit positions
   localparam int unsigned CTRL_LINE_EN    = 0;
   localparam int unsigned CTRL_FRAME_EN   = 1;
   localparam int unsigned CTRL_WIDTH_MODE = 2;

   // status / mask bit positions
   localparam int unsigned ST_LINE_OVT   = 0;
   localparam int unsigned ST_FRAME_OVT  = 1;
   localparam int unsigned ST_FRAME_DONE = 2;
   localparam int unsigned ST_TX_START   = 3;

   // state register bit positions
   localparam int unsigned STB_LINE_WAIT  = 0;
   localparam int unsigned STB_FRAME_WAIT = 1;
   localparam int unsigned STB_TX_PEND    = 2;

   // values after reset, counts are in 50 ns clock cycles
   localparam logic [DW-1:0]     CTRL_RST     = 16'h0000;
   localparam logic [DW-1:0]     EXPOSURE_RST = 16'h0064;
   localparam logic [DW-1:0]     OVERLAP_RST  = 16'h0050;
   localparam logic [DW-1:0]     READOUT_RST  = 16'h00FA;
   localparam logic [DW-1:0]     HEIGHT_RST   = 16'h0003;
   localparam logic [DW-1:0]     TX_DELAY_RST = 16'h0010;
   localparam logic [DW-1:0]     ZERO_W       = 16'h0000;
   localparam logic [DW-1:0]     ONE_W        = 16'h0001;
   localparam logic [JIT_W-1:0]  LFSR_SEED    = 4'h1;
   localparam logic [STAT_W-1:0] STAT_ZERO    = 4'h0;

   // output line selector and source codes
   localparam logic       sel_output_one = 1'b0;
   localparam logic       sel_output_two = 1'b1;
   localparam logic [1:0] src_off        = 2'h0;
   localparam logic [1:0] src_line_wait  = 2'h1;
   localparam logic [1:0] src_frame_wait = 2'h2;
   localparam logic [1:0] src_high       = 2'h3;
   localparam logic [1:0] SRC_OUT1_RST   = src_off;
   localparam logic [1:0] SRC_OUT2_RST   = src_frame_wait;

   typedef enum logic [1:0] {LS_OFF, LS_WAIT, LS_EXPOSE, LS_HOLD} ltw_line_state_t;
   typedef enum logic {FS_WAIT, FS_ACQ} ltw_frame_state_t;
endpackage

// ### design/ltw_sync.sv
// two flip-flop synchroniser for asynchronous trigger pins
`timescale 1ns/100ps
module ltw_sync #(
   parameter int unsigned WIDTH = 2
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   // the first stage feeds only the second stage
   always_comb
   begin
      meta_d = rstn ? async_in : '0;
      sync_d = rstn ? meta_q : '0;
   end

   always_ff @(posedge clk)
   begin
      meta_q <= meta_d;
      sync_q <= sync_d;
   end

   assign sync_out = sync_q;
endmodule

// ### design/ltw_top.sv
// line and frame trigger wait logic with output line routing and frame send start
//
// Summary of operation
// - line wait output rises whenever the block enters waiting for a line trigger.
// - line wait output falls when an accepted line start trigger leaves waiting.
// - line triggers during exposure or readout hold are ignored and flag line overtrigger; while disabled they flag nothing.
// - timed mode: line wait rises once remaining readout fits within exposure time.
// - width mode: line wait rises once remaining readout fits within overlap limit.
// - line wait can be routed to a selected output line via select then source.
// - frame wait can be routed to a selected output line the same way.
// - frame sending starts only after the whole frame is collected.
// - a variable delay, changing per frame, precedes the start of sending.
// - frame wait rises entering frame wait state, falls on accepted frame trigger.
// - frame wait is only given while hardware frame triggering is enabled.
// - after reset output line two carries frame wait; software may change it.
`timescale 1ns/100ps
module ltw_top #(
   parameter int unsigned DW = ltw_pkg::DW
) (
   input  wire logic                          clk,
   input  wire logic                          rstn,
   input  wire logic [ltw_pkg::AW-1:0]        reg_addr,
   input  wire logic [DW-1:0]                 reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output logic      [DW-1:0]                 reg_rdata,
   input  wire logic                          ext_line_start_trigger,
   input  wire logic                          ext_frame_start_trigger,
   output logic                               line_wait,
   output logic                               frame_wait,
   output logic      [ltw_pkg::NUM_OUT-1:0]   out_line,
   output logic                               tx_start,
   output logic                               irq
);
   logic [1:0]                  trig_sync;
   logic                        lt_lvl;
   logic                        ft_lvl;
   logic                        lt_prev_q;
   logic                        ft_prev_q;
   logic                        lt_edge;
   logic                        ft_edge;

   logic [DW-1:0]               ctrl_q;
   logic [DW-1:0]               ctrl_d;
   logic [DW-1:0]               exposure_q;
   logic [DW-1:0]               exposure_d;
   logic [DW-1:0]               overlap_q;
   logic [DW-1:0]               overlap_d;
   logic [DW-1:0]               readout_q;
   logic [DW-1:0]               readout_d;
   logic [DW-1:0]               height_q;
   logic [DW-1:0]               height_d;
   logic [DW-1:0]               tx_delay_q;
   logic [DW-1:0]               tx_delay_d;
   logic                        line_sel_q;
   logic                        line_sel_d;
   logic [1:0]                  src_q [ltw_pkg::NUM_OUT];
   logic [1:0]                  src_d [ltw_pkg::NUM_OUT];
   logic [ltw_pkg::STAT_W-1:0]  status_q;
   logic [ltw_pkg::STAT_W-1:0]  status_d;
   logic [ltw_pkg::STAT_W-1:0]  mask_q;
   logic [ltw_pkg::STAT_W-1:0]  mask_d;
   logic [ltw_pkg::STAT_W-1:0]  events;
   logic [DW-1:0]               rdata_q;
   logic [DW-1:0]               rdata_d;
   ltw_pkg::ltw_line_state_t    ls_q;
   ltw_pkg::ltw_line_state_t    ls_d;
   logic [DW-1:0]               exp_cnt_q;
   logic [DW-1:0]               exp_cnt_d;
   logic [DW-1:0]               rd_cnt_q;
   logic [DW-1:0]               rd_cnt_d;
   logic                        line_done;
   logic                        line_ovt;
   logic [DW-1:0]               limit;
   logic                        line_en;
   logic                        frame_en;
   logic                        width_mode;
   ltw_pkg::ltw_frame_state_t   fs_q;
   ltw_pkg::ltw_frame_state_t   fs_d;
   logic [DW-1:0]               line_cnt_q;
   logic [DW-1:0]               line_cnt_d;
   logic                        frame_ovt;
   logic                        frame_done;
   logic [DW-1:0]               tx_cnt_q;
   logic [DW-1:0]               tx_cnt_d;
   logic                        tx_pend_q;
   logic                        tx_pend_d;
   logic [ltw_pkg::JIT_W-1:0]   lfsr_q;
   logic [ltw_pkg::JIT_W-1:0]   lfsr_d;
   logic                        tx_fire;

   logic                        line_wait_q;
   logic                        line_wait_d;
   logic                        frame_wait_q;
   logic                        frame_wait_d;
   logic [ltw_pkg::NUM_OUT-1:0] out_q;
   logic [ltw_pkg::NUM_OUT-1:0] out_d;
   logic                        tx_start_q;
   logic                        irq_q;
   logic                        irq_d;

   ltw_sync #(
      .WIDTH    (2)
   ) u_sync (
      .clk      (clk),
      .rstn     (rstn),
      .async_in ({ext_frame_start_trigger, ext_line_start_trigger}),
      .sync_out (trig_sync)
   );

   assign lt_lvl     = trig_sync[0];
   assign ft_lvl     = trig_sync[1];
   assign lt_edge    = lt_lvl & ~lt_prev_q;
   assign ft_edge    = ft_lvl & ~ft_prev_q;
   assign line_en    = ctrl_q[ltw_pkg::CTRL_LINE_EN];
   assign frame_en   = ctrl_q[ltw_pkg::CTRL_FRAME_EN];
   assign width_mode = ctrl_q[ltw_pkg::CTRL_WIDTH_MODE];
   // timed mode uses the exposure time, width mode the overlap limit
   assign limit      = width_mode ? overlap_q : exposure_q;

   // line state: one exposure at a time, its readout may overlap the next exposure
   always_comb
   begin
      ls_d      = ls_q;
      exp_cnt_d = exp_cnt_q;
      rd_cnt_d  = (rd_cnt_q != ltw_pkg::ZERO_W) ? rd_cnt_q - ltw_pkg::ONE_W : rd_cnt_q;
      line_done = (rd_cnt_q == ltw_pkg::ONE_W);
      line_ovt  = 1'b0;
      case (ls_q)
         ltw_pkg::LS_OFF:
         begin
            if (line_en)
            begin
               ls_d = ltw_pkg::LS_HOLD;
            end
         end
         ltw_pkg::LS_WAIT:
         begin
            if (lt_edge)
            begin
               ls_d      = ltw_pkg::LS_EXPOSE;
               exp_cnt_d = exposure_q;
            end
         end
         ltw_pkg::LS_EXPOSE:
         begin
            line_ovt  = lt_edge;
            exp_cnt_d = (exp_cnt_q != ltw_pkg::ZERO_W) ? exp_cnt_q - ltw_pkg::ONE_W
                                                       : exp_cnt_q;
            // width mode ends exposure with the trigger pulse, timed mode by count
            if (width_mode ? !lt_lvl : (exp_cnt_q <= ltw_pkg::ONE_W))
            begin
               ls_d      = ltw_pkg::LS_HOLD;
               rd_cnt_d  = readout_q;
               line_done = 1'b0;
            end
         end
         ltw_pkg::LS_HOLD:
         begin
            line_ovt = lt_edge;
            if (rd_cnt_q <= limit)
            begin
               ls_d = ltw_pkg::LS_WAIT;
            end
         end
         default:
         begin
            ls_d = ltw_pkg::LS_OFF;
         end
      endcase
      if (!line_en)
      begin
         ls_d     = ltw_pkg::LS_OFF;
         line_ovt = 1'b0;
      end
   end

   // frame state and delayed start of sending
   always_comb
   begin
      fs_d       = fs_q;
      line_cnt_d = line_cnt_q;
      frame_ovt  = 1'b0;
      frame_done = 1'b0;
      lfsr_d     = {lfsr_q[ltw_pkg::JIT_W-2:0], lfsr_q[3] ^ lfsr_q[2]};
      tx_cnt_d   = (tx_cnt_q != ltw_pkg::ZERO_W) ? tx_cnt_q - ltw_pkg::ONE_W : tx_cnt_q;
      tx_fire    = tx_pend_q && (tx_cnt_q == ltw_pkg::ZERO_W);
      tx_pend_d  = tx_pend_q && !tx_fire;
      case (fs_q)
         ltw_pkg::FS_WAIT:
         begin
            // without hardware frame triggering the next frame starts at once
            if (!frame_en || ft_edge)
            begin
               fs_d       = ltw_pkg::FS_ACQ;
               line_cnt_d = ltw_pkg::ZERO_W;
            end
         end
         ltw_pkg::FS_ACQ:
         begin
            frame_ovt = frame_en && ft_edge;
            if (line_done)
            begin
               line_cnt_d = line_cnt_q + ltw_pkg::ONE_W;
               if (line_cnt_d >= height_q)
               begin
                  fs_d       = ltw_pkg::FS_WAIT;
                  frame_done = 1'b1;
               end
            end
         end
         default:
         begin
            fs_d = ltw_pkg::FS_WAIT;
         end
      endcase
      if (frame_done)
      begin
         // a new complete frame restarts the wait; jitter varies it per frame
         tx_pend_d = 1'b1;
         tx_cnt_d  = tx_delay_q + {{(DW-ltw_pkg::JIT_W){1'b0}}, lfsr_q};
      end
   end

   // register file: writes, read data and sticky status
   always_comb
   begin
      ctrl_d     = ctrl_q;
      exposure_d = exposure_q;
      overlap_d  = overlap_q;
      readout_d  = readout_q;
      height_d   = height_q;
      tx_delay_d = tx_delay_q;
      line_sel_d = line_sel_q;
      mask_d     = mask_q;
      src_d      = src_q;
      rdata_d    = ltw_pkg::ZERO_W;
      events     = {tx_fire, frame_done, frame_ovt, line_ovt};
      status_d   = status_q;
      if (reg_wr)
      begin
         case (reg_addr)
            ltw_pkg::REG_CTRL:        ctrl_d     = reg_wdata;
            ltw_pkg::REG_EXPOSURE:    exposure_d = reg_wdata;
            ltw_pkg::REG_OVERLAP:     overlap_d  = reg_wdata;
            ltw_pkg::REG_READOUT:     readout_d  = reg_wdata;
            ltw_pkg::REG_HEIGHT:      height_d   = reg_wdata;
            ltw_pkg::REG_TX_DELAY:    tx_delay_d = reg_wdata;
            ltw_pkg::REG_LINE_SELECT: line_sel_d = reg_wdata[0];
            ltw_pkg::REG_LINE_SOURCE: src_d[line_sel_q] = reg_wdata[1:0];
            ltw_pkg::REG_MASK:        mask_d     = reg_wdata[ltw_pkg::STAT_W-1:0];
            default:                  ctrl_d     = ctrl_q;
         endcase
      end
      if (reg_rd)
      begin
         case (reg_addr)
            ltw_pkg::REG_CTRL:        rdata_d = ctrl_q;
            ltw_pkg::REG_EXPOSURE:    rdata_d = exposure_q;
            ltw_pkg::REG_OVERLAP:     rdata_d = overlap_q;
            ltw_pkg::REG_READOUT:     rdata_d = readout_q;
            ltw_pkg::REG_HEIGHT:      rdata_d = height_q;
            ltw_pkg::REG_TX_DELAY:    rdata_d = tx_delay_q;
            ltw_pkg::REG_LINE_SELECT: rdata_d = {{(DW-1){1'b0}}, line_sel_q};
            ltw_pkg::REG_LINE_SOURCE: rdata_d = {{(DW-2){1'b0}}, src_q[line_sel_q]};
            ltw_pkg::REG_STATUS:
            begin
               rdata_d  = {{(DW-ltw_pkg::STAT_W){1'b0}}, status_q};
               status_d = ltw_pkg::STAT_ZERO;
            end
            ltw_pkg::REG_MASK:        rdata_d = {{(DW-ltw_pkg::STAT_W){1'b0}}, mask_q};
            ltw_pkg::REG_STATE:
            begin
               rdata_d[ltw_pkg::STB_LINE_WAIT]  = line_wait_q;
               rdata_d[ltw_pkg::STB_FRAME_WAIT] = frame_wait_q;
               rdata_d[ltw_pkg::STB_TX_PEND]    = tx_pend_q;
            end
            default:                  rdata_d = ltw_pkg::ZERO_W;
         endcase
      end
      // an event in the clearing read's cycle survives the clear
      status_d = status_d | events;
      irq_d    = |(status_d & mask_d);
   end

   // wait flags and output line routing
   always_comb
   begin
      line_wait_d  = (ls_d == ltw_pkg::LS_WAIT);
      frame_wait_d = frame_en && (fs_d == ltw_pkg::FS_WAIT);
      for (int i = 0; i < ltw_pkg::NUM_OUT; i++)
      begin
         case (src_q[i])
            ltw_pkg::src_line_wait:  out_d[i] = line_wait_q;
            ltw_pkg::src_frame_wait: out_d[i] = frame_wait_q;
            ltw_pkg::src_high:       out_d[i] = 1'b1;
            default:                 out_d[i] = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         lt_prev_q    <= 1'b0;
         ft_prev_q    <= 1'b0;
         ctrl_q       <= ltw_pkg::CTRL_RST;
         exposure_q   <= ltw_pkg::EXPOSURE_RST;
         overlap_q    <= ltw_pkg::OVERLAP_RST;
         readout_q    <= ltw_pkg::READOUT_RST;
         height_q     <= ltw_pkg::HEIGHT_RST;
         tx_delay_q   <= ltw_pkg::TX_DELAY_RST;
         line_sel_q   <= ltw_pkg::sel_output_one;
         src_q[0]     <= ltw_pkg::SRC_OUT1_RST;
         src_q[1]     <= ltw_pkg::SRC_OUT2_RST;
         status_q     <= ltw_pkg::STAT_ZERO;
         mask_q       <= ltw_pkg::STAT_ZERO;
         rdata_q      <= ltw_pkg::ZERO_W;
         ls_q         <= ltw_pkg::LS_OFF;
         exp_cnt_q    <= ltw_pkg::ZERO_W;
         rd_cnt_q     <= ltw_pkg::ZERO_W;
         fs_q         <= ltw_pkg::FS_WAIT;
         line_cnt_q   <= ltw_pkg::ZERO_W;
         tx_cnt_q     <= ltw_pkg::ZERO_W;
         tx_pend_q    <= 1'b0;
         lfsr_q       <= ltw_pkg::LFSR_SEED;
         line_wait_q  <= 1'b0;
         frame_wait_q <= 1'b0;
         out_q        <= '0;
         tx_start_q   <= 1'b0;
         irq_q        <= 1'b0;
      end
      else
      begin
         lt_prev_q    <= lt_lvl;
         ft_prev_q    <= ft_lvl;
         ctrl_q       <= ctrl_d;
         exposure_q   <= exposure_d;
         overlap_q    <= overlap_d;
         readout_q    <= readout_d;
         height_q     <= height_d;
         tx_delay_q   <= tx_delay_d;
         line_sel_q   <= line_sel_d;
         src_q        <= src_d;
         status_q     <= status_d;
         mask_q       <= mask_d;
         rdata_q      <= rdata_d;
         ls_q         <= ls_d;
         exp_cnt_q    <= exp_cnt_d;
         rd_cnt_q     <= rd_cnt_d;
         fs_q         <= fs_d;
         line_cnt_q   <= line_cnt_d;
         tx_cnt_q     <= tx_cnt_d;
         tx_pend_q    <= tx_pend_d;
         lfsr_q       <= lfsr_d;
         line_wait_q  <= line_wait_d;
         frame_wait_q <= frame_wait_d;
         out_q        <= out_d;
         tx_start_q   <= tx_fire;
         irq_q        <= irq_d;
      end
   end

   assign reg_rdata  = rdata_q;
   assign line_wait  = line_wait_q;
   assign frame_wait = frame_wait_q;
   assign out_line   = out_q;
   assign tx_start   = tx_start_q;
   assign irq        = irq_q;
endmodule

// ### verification/ltw_assertions.sv
// port-level checks of the line trigger wait block
`timescale 1ns/100ps
module ltw_assertions #(
   parameter int unsigned DW = ltw_pkg::DW
) (
   input wire logic                        clk,
   input wire logic                        rstn,
   input wire logic [ltw_pkg::AW-1:0]      reg_addr,
   input wire logic [DW-1:0]               reg_wdata,
   input wire logic                        reg_wr,
   input wire logic                        reg_rd,
   input wire logic [DW-1:0]               reg_rdata,
   input wire logic                        ext_line_start_trigger,
   input wire logic                        ext_frame_start_trigger,
   input wire logic                        line_wait,
   input wire logic                        frame_wait,
   input wire logic [ltw_pkg::NUM_OUT-1:0] out_line,
   input wire logic                        tx_start,
   input wire logic                        irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence line_taken;
      $rose(ext_line_start_trigger) ##0 line_wait;
   endsequence
   sequence frame_taken;
      $rose(ext_frame_start_trigger) ##0 frame_wait;
   endsequence
   reset_quiet_a: assert property ($rose(rstn) |-> !line_wait && !frame_wait && !tx_start
      && !irq && out_line == '0 && reg_rdata == '0) else $error("outputs busy after reset");
   line_drop_a: assert property (line_taken |-> ##[1:6] $fell(line_wait))
      else $error("line wait kept after trigger");
   low_hold_a: assert property ($fell(line_wait) |-> !line_wait [*8])
      else $error("line wait back too soon");
   frame_drop_a: assert property (frame_taken |-> ##[1:6] $fell(frame_wait))
      else $error("frame wait kept after trigger");
   read_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
      else $error("read data without read");
   unmapped_read_a: assert property ($past(reg_rd) && $past(reg_addr) > ltw_pkg::REG_STATE
      |-> reg_rdata == '0) else $error("unmapped read not zero");
   tx_pulse_a: assert property (tx_start |=> !tx_start)
      else $error("send start longer than one cycle");
   tx_gap_a: assert property ($rose(frame_wait) |-> !tx_start [*8])
      else $error("send start right at frame end");
endmodule

bind ltw_top ltw_assertions #(.DW(DW)) u_ltw_chk (
   .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_line_start_trigger(ext_line_start_trigger),
   .ext_frame_start_trigger(ext_frame_start_trigger), .line_wait(line_wait),
   .frame_wait(frame_wait), .out_line(out_line), .tx_start(tx_start), .irq(irq));

// ### verification/ltw_trig_src.sv
// external line trigger source that normally fires only while the camera waits
`timescale 1ns/100ps
module ltw_trig_src (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        line_wait,
   input  wire logic        fire,
   input  wire logic        ignore_wait,
   input  wire logic [15:0] width,
   output logic             trig
);
   logic [15:0] cnt_q;
   logic        pend_q;
   initial trig = 1'b0;
   always @(posedge clk)
   begin
      if (!rstn)
      begin
         trig   <= 1'b0;
         cnt_q  <= 16'h0000;
         pend_q <= 1'b0;
      end
      else if (cnt_q != 16'h0000)
      begin
         // pulse held its full width so width-mode exposure never undercuts the limit
         cnt_q <= cnt_q - 16'h0001;
         if (cnt_q == 16'h0001)
            trig <= 1'b0;
      end
      else if ((fire || pend_q) && (line_wait || ignore_wait))
      begin
         trig   <= 1'b1;
         cnt_q  <= width;
         pend_q <= 1'b0;
      end
      else if (fire)
         pend_q <= 1'b1;
   end
endmodule

// ### verification/test_ltw_top.sv
// self-checking bench for the line trigger wait block
`timescale 1ns/100ps
module test_ltw_top;
   logic                      clk, rstn, reg_wr, reg_rd, fire, ignore_wait;
   logic                      ext_line_start_trigger, ext_frame_start_trigger;
   logic [ltw_pkg::AW-1:0]    reg_addr;
   logic [15:0]               reg_wdata, reg_rdata, width, lfsr, d;
   logic                      line_wait, frame_wait, tx_start, irq;
   logic [ltw_pkg::NUM_OUT-1:0] out_line;
   int                        err_count = 0, checked = 0, cycles = 0, n;

   ltw_top dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .ext_line_start_trigger(ext_line_start_trigger),
      .ext_frame_start_trigger(ext_frame_start_trigger), .line_wait(line_wait),
      .frame_wait(frame_wait), .out_line(out_line), .tx_start(tx_start), .irq(irq));
   ltw_trig_src u_src (.clk(clk), .rstn(rstn), .line_wait(line_wait), .fire(fire),
      .ignore_wait(ignore_wait), .width(width), .trig(ext_line_start_trigger));

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic sig(input int s);
      return (s == 0) ? line_wait : (s == 1) ? frame_wait : tx_start;
   endfunction
   function automatic logic [15:0] rst_val(input logic [3:0] a);
      case (a)
         ltw_pkg::REG_EXPOSURE: return ltw_pkg::EXPOSURE_RST;
         ltw_pkg::REG_OVERLAP:  return ltw_pkg::OVERLAP_RST;
         ltw_pkg::REG_READOUT:  return ltw_pkg::READOUT_RST;
         ltw_pkg::REG_HEIGHT:   return ltw_pkg::HEIGHT_RST;
         ltw_pkg::REG_TX_DELAY: return ltw_pkg::TX_DELAY_RST;
         default:               return 16'h0000;
      endcase
   endfunction
   // low time of the wait output: exposure plus readout left beyond the limit
   function automatic int low_time(input logic [15:0] x, input logic [15:0] lim,
                                   input logic [15:0] r);
      return int'(x) + ((r > lim) ? int'(r - lim) : 0);
   endfunction

   task complete_run;
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task tick;
      @(posedge clk);
      #1;
   endtask
   task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task chkb(input string nm, input logic exp, input logic got);
      chk(nm, {15'h0000, exp}, {15'h0000, got});
   endtask
   task chk_rng(input string nm, input int lo, input int hi, input int got);
      checked++;
      if (got < lo || got > hi)
      begin
         err_count++;
         $display("ERROR %s expected %0d to %0d seen %0d", nm, lo, hi, got);
      end
   endtask
   task wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task wait_sig(input int s, input logic v, output int k);
      k = 0;
      while (sig(s) !== v && k < 3000)
      begin
         tick();
         k++;
      end
      chk_rng("wait for output", 0, 2999, k);
   endtask
   task fire_trig(input logic ign, input logic [15:0] w);
      @(posedge clk);
      ignore_wait <= ign;
      width       <= w;
      fire        <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
   endtask
   task frame_pulse;
      @(posedge clk);
      ext_frame_start_trigger <= 1'b1;
      repeat (6) @(posedge clk);
      ext_frame_start_trigger <= 1'b0;
   endtask
   task run_line(input logic wmode);
      logic [15:0] e, r, w;
      int          k, t;
      lfsr = lfsr_next(lfsr);
      e = 16'h0008 + lfsr[4:0];
      lfsr = lfsr_next(lfsr);
      r = 16'h0008 + lfsr[5:0];
      w = e + lfsr[9:6];
      wr(ltw_pkg::REG_CTRL, wmode ? 16'h0007 : 16'h0003);
      wr(ltw_pkg::REG_READOUT, r);
      wr(wmode ? ltw_pkg::REG_OVERLAP : ltw_pkg::REG_EXPOSURE, e);
      fire_trig(1'b0, wmode ? w : 16'h0008);
      wait_sig(0, 1'b0, k);
      wait_sig(0, 1'b1, k);
      t = low_time(wmode ? w : e, e, r);
      chk_rng("line wait low", t - 2, t + 5, k);
   endtask

   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         err_count++;
         complete_run();
      end
   end

   initial
   begin
      {rstn, reg_wr, reg_rd, fire, ignore_wait, ext_frame_start_trigger} = 6'h00;
      reg_addr  = 4'h0;
      reg_wdata = 16'h0000;
      width     = 16'h0008;
      lfsr      = 16'h002B;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      for (int i = 0; i < 12; i++)
      begin
         rd(4'(i), d);
         chk("reset value", rst_val(4'(i)), d);
      end
      wr(ltw_pkg::REG_LINE_SELECT, 16'h0001);
      rd(ltw_pkg::REG_LINE_SOURCE, d);
      chk("line two source", 16'h0002, d);
      fire_trig(1'b1, 16'h0008);
      repeat (12) tick();
      chkb("line wait disabled", 1'b0, line_wait);
      rd(ltw_pkg::REG_STATUS, d);
      chkb("event while disabled", 1'b0, d[ltw_pkg::ST_LINE_OVT]);
      wr(ltw_pkg::REG_MASK, 16'h0001);
      wr(ltw_pkg::REG_HEIGHT, 16'h0001);
      wr(ltw_pkg::REG_CTRL, 16'h0003);
      repeat (4) tick();
      chkb("line wait armed", 1'b1, line_wait);
      fire_trig(1'b0, 16'h0008);
      wait_sig(1, 1'b1, n);
      tick();
      chkb("frame wait armed", 1'b1, frame_wait);
      chkb("line two output", 1'b1, out_line[1]);
      frame_pulse();
      repeat (8) tick();
      chkb("frame wait taken", 1'b0, frame_wait);
      frame_pulse();
      repeat (6) tick();
      rd(ltw_pkg::REG_STATUS, d);
      chkb("frame overtrigger", 1'b1, d[ltw_pkg::ST_FRAME_OVT]);
      wr(ltw_pkg::REG_LINE_SELECT, 16'h0000);
      for (int s = 0; s < 4; s++)
      begin
         wr(ltw_pkg::REG_LINE_SOURCE, 16'(s));
         repeat (3) tick();
         chkb("routed line one", s == 1 || s == 3, out_line[0]);
      end
      chkb("line two follows", 1'b0, out_line[1]);
      wr(ltw_pkg::REG_EXPOSURE, 16'h0028);
      wr(ltw_pkg::REG_READOUT, 16'h003C);
      fire_trig(1'b0, 16'h0008);
      wait_sig(0, 1'b0, n);
      repeat (10) tick();
      fire_trig(1'b1, 16'h001E);
      repeat (8) tick();
      chkb("ignored trigger", 1'b0, line_wait);
      chkb("irq on overtrigger", 1'b1, irq);
      rd(ltw_pkg::REG_STATUS, d);
      chkb("line overtrigger", 1'b1, d[ltw_pkg::ST_LINE_OVT]);
      rd(ltw_pkg::REG_STATUS, d);
      chkb("single overtrigger", 1'b0, d[ltw_pkg::ST_LINE_OVT]);
      repeat (2) tick();
      chkb("irq cleared", 1'b0, irq);
      wait_sig(0, 1'b1, n);
      run_line(1'b0);
      run_line(1'b1);
      wait_sig(1, 1'b1, n);
      repeat (40) tick();
      frame_pulse();
      fire_trig(1'b0, 16'h0028);
      wait_sig(1, 1'b1, n);
      wait_sig(2, 1'b1, n);
      chk_rng("send delay", 16, 34, n);
      chkb("irq masked", 1'b0, irq);
      rd(ltw_pkg::REG_STATUS, d);
      chk("frame events", 16'h000C, d & 16'h000C);
      wr(ltw_pkg::REG_CTRL, 16'h0000);
      repeat (3) tick();
      chkb("line wait off", 1'b0, line_wait);
      chkb("frame wait off", 1'b0, frame_wait);
      complete_run();
   end
endmodule
